// ---- rtl/tx_buffer_cmd_status.sv ----
`timescale 1ns/1ps
`include "tx_buffer_defines.svh"
module tx_buffer_cmd_status (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // mac transmitter stream
    output tx_buffer_pkg::mac_tx_s mac_tx,
    input wire logic mac_ready,
    // mac transmitter frame outcome
    input wire logic mac_done,
    input wire tx_buffer_pkg::mac_result_s mac_result,
    // sticky error
    output logic transmit_error_flag
);
    import tx_buffer_pkg::*;

    state_s q;
    state_s d;

    // storage arrays: byte fifo with last mark, frame info, status words
    logic [8:0] data_mem [0:(1 << `DATA_AW) - 1];
    logic [17:0] info_mem [0:(1 << `INFO_AW) - 1];
    logic [31:0] stat_mem [0:(1 << `STAT_AW) - 1];

    logic data_we;
    logic [8:0] data_wd;
    logic info_we;
    logic [17:0] info_wd;
    logic st_we;
    logic [31:0] st_wd;

    // words occupied by a buffer after offset, size and end filler
    function automatic logic [9:0] buf_words(input logic [5:0] off, input logic [10:0] size,
                                             input logic [1:0] align);
        logic [11:0] e;
        logic [11:0] m;
        logic [11:0] r;
        e = {6'h00, off} + {1'b0, size};
        if (align == `ALIGN_16) begin
            m = `ALIGN_MASK_16;
        end else if (align == `ALIGN_32) begin
            m = `ALIGN_MASK_32;
        end else begin
            m = `ALIGN_MASK_4;
        end
        r = (e + m) & ~m;
        return r[11:2];
    endfunction

    // byte position within the data words holds payload
    function automatic logic lane_hit(input logic [11:0] pos, input logic [5:0] off,
                                      input logic [10:0] size);
        logic [11:0] lo;
        logic [11:0] hi;
        lo = {6'h00, off};
        hi = lo + {1'b0, size};
        return (pos >= lo) && (pos < hi);
    endfunction

    // next-state logic
    always_comb begin
        logic acc;
        logic [11:0] data_cnt;
        logic data_full;
        logic data_empty;
        logic info_full;
        logic info_empty;
        logic [4:0] st_used;
        logic st_full;
        logic [5:0] off;
        logic [10:0] size;
        logic [11:0] pos;
        logic [11:0] end_pos;
        logic [11:0] cum_n;
        logic advance;
        logic pkt_inc;
        logic pkt_dec;
        logic [8:0] head;
        logic [31:0] stat;
        logic st_read;
        d = q;
        data_we = 1'b0;
        data_wd = 9'h000;
        info_we = 1'b0;
        info_wd = 18'h00000;
        st_we = 1'b0;
        st_wd = 32'h00000000;
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        acc = psel & penable & ~q.pready;
        data_cnt = q.wr_ptr - q.rd_ptr;
        data_full = data_cnt[11];
        data_empty = (data_cnt == 12'h000);
        info_full = ((q.info_wr - q.info_rd) == 3'h4);
        info_empty = (q.info_wr == q.info_rd);
        st_used = q.st_wr - q.st_rd;
        st_full = st_used[4];
        off = q.cmda[`CMDA_OFF_MSB:`CMDA_OFF_LSB];
        size = q.cmda[`CMDA_SIZE_MSB:0];
        pos = {q.widx, q.lane};
        end_pos = {6'h00, off} + {1'b0, size} - 12'h001;
        cum_n = q.cum;
        advance = 1'b0;
        pkt_inc = 1'b0;
        pkt_dec = 1'b0;
        head = data_mem[q.rd_ptr[`DATA_AW-1:0]];
        stat = 32'h00000000;
        st_read = 1'b0;

        // host side: register access and buffer parsing
        if (acc && q.hst == H_UNPACK) begin
            // one byte lane per cycle; only payload bytes reach the fifo
            if (lane_hit(pos, off, size)) begin
                if (!data_full) begin
                    data_we = 1'b1;
                    data_wd = {q.cmda[`CMDA_LAST_BIT] && (pos == end_pos),
                               q.word[{q.lane, 3'h0} +: 8]};
                    d.wr_ptr = q.wr_ptr + 12'h001;
                    cum_n = q.cum + 12'h001;
                    advance = 1'b1;
                end
            end else begin
                advance = 1'b1;
            end
            d.cum = cum_n;
            if (advance) begin
                d.lane = q.lane + 2'h1;
                if (q.lane == 2'h3) begin
                    d.pready = 1'b1;
                    d.widx = q.widx + 10'h001;
                    if (q.widx + 10'h001 == q.words) begin
                        d.hst = H_CMDA;
                        if (q.cmda[`CMDA_LAST_BIT]) begin
                            pkt_inc = 1'b1;
                            if (cum_n != {1'b0, q.pkt_b[`CMDB_LEN_MSB:0]}) begin
                                d.err = 1'b1;
                            end
                        end
                    end else begin
                        d.hst = H_DATA;
                    end
                end
            end
        end else if (acc) begin
            d.prdata = 32'h00000000;
            case (paddr)
                `ADDR_TX_DATA: begin
                    if (pwrite) begin
                        case (q.hst)
                            H_CMDA: begin
                                d.cmda = pwdata;
                                d.hst = H_CMDB;
                                d.pready = 1'b1;
                            end
                            H_CMDB: begin
                                if (!(q.cmda[`CMDA_FIRST_BIT] && info_full)) begin
                                    d.pready = 1'b1;
                                    d.widx = 10'h000;
                                    d.lane = 2'h0;
                                    d.words = buf_words(off, size,
                                        q.cmda[`CMDA_ALIGN_MSB:`CMDA_ALIGN_LSB]);
                                    if (q.cmda[`CMDA_FIRST_BIT]) begin
                                        d.pkt_b = pwdata;
                                        d.cum = 12'h000;
                                        info_we = 1'b1;
                                        info_wd = {pwdata[31:`CMDB_TAG_LSB],
                                                   pwdata[`CMDB_CRC_DIS_BIT],
                                                   pwdata[`CMDB_PAD_DIS_BIT]};
                                        d.info_wr = q.info_wr + 3'h1;
                                    end else if (pwdata != q.pkt_b) begin
                                        d.err = 1'b1;
                                    end
                                    if (d.words == 10'h000) begin
                                        d.hst = H_CMDA;
                                    end else begin
                                        d.hst = H_DATA;
                                    end
                                end
                            end
                            H_DATA: begin
                                d.word = pwdata;
                                d.lane = 2'h0;
                                d.hst = H_UNPACK;
                            end
                            default: begin
                                d.hst = H_CMDA;
                            end
                        endcase
                    end else begin
                        d.pready = 1'b1;
                    end
                end
                `ADDR_TX_STATUS: begin
                    d.pready = 1'b1;
                    if (!pwrite && st_used != 5'h00) begin
                        d.prdata = stat_mem[q.st_rd[`STAT_AW-1:0]];
                        d.st_rd = q.st_rd + 5'h01;
                        st_read = 1'b1;
                    end
                end
                `ADDR_TX_CONFIG: begin
                    d.pready = 1'b1;
                    if (pwrite) begin
                        d.cfg = pwdata[2:0];
                    end else begin
                        d.prdata = {29'h00000000, q.cfg};
                    end
                end
                `ADDR_TX_INFO: begin
                    d.pready = 1'b1;
                    if (pwrite) begin
                        if (pwdata[`INFO_ERROR_BIT]) begin
                            d.err = 1'b0;
                        end
                    end else begin
                        d.prdata[`INFO_ERROR_BIT] = q.err;
                        d.prdata[`INFO_USED_MSB:0] = q.st_over ? 5'h00 : st_used;
                    end
                end
                default: begin
                    d.pready = 1'b1;
                    d.pslverr = 1'b1;
                end
            endcase
        end
        if (st_read) begin
            d.st_over = 1'b0;
        end

        // transmit side: feed the mac and collect the frame outcome
        case (q.tst)
            T_IDLE: begin
                if (!info_empty && (q.cfg[`CFG_DISCARD_OVERRUN_BIT] || !st_full) &&
                    (q.cfg[`CFG_STORE_FORWARD_BIT] ? (q.pkt_ready != 12'h000)
                                                   : !data_empty)) begin
                    d.cur_info = info_mem[q.info_rd[`INFO_AW-1:0]];
                    d.info_rd = q.info_rd + 3'h1;
                    d.mac.crc_en = ~d.cur_info[1] | d.cur_info[0];
                    d.mac.pad_en = ~d.cur_info[0];
                    d.tst = T_SEND;
                end
            end
            T_SEND: begin
                if (!q.mac.valid || mac_ready) begin
                    if (!data_empty) begin
                        d.mac.valid = 1'b1;
                        d.mac.data = head[7:0];
                        d.mac.last = head[8];
                        d.rd_ptr = q.rd_ptr + 12'h001;
                        if (head[8]) begin
                            pkt_dec = 1'b1;
                            d.tst = T_WAIT;
                        end
                    end else begin
                        d.mac.valid = 1'b0;
                    end
                end
            end
            T_WAIT: begin
                if (q.mac.valid && mac_ready) begin
                    d.mac.valid = 1'b0;
                    d.mac.last = 1'b0;
                end
                if (mac_done) begin
                    stat[31:16] = q.cur_info[17:2];
                    stat[11] = mac_result.loss_carrier;
                    stat[10] = mac_result.no_carrier;
                    stat[9] = mac_result.late_collision;
                    stat[8] = mac_result.excess_collisions;
                    stat[6:3] = mac_result.collision_count;
                    stat[2] = mac_result.excess_deferral &
                              q.cfg[`CFG_DEFER_CHECK_BIT];
                    stat[1] = mac_result.underrun;
                    stat[0] = mac_result.deferred;
                    stat[15] = stat[11] | stat[10] | stat[9] | stat[8] |
                               stat[2] | stat[1];
                    if (mac_result.underrun) begin
                        d.err = 1'b1;
                    end
                    if (st_full || (q.st_over && !st_read)) begin
                        if (q.cfg[`CFG_DISCARD_OVERRUN_BIT]) begin
                            d.st_over = 1'b1;
                        end else begin
                            d.err = 1'b1;
                        end
                    end else begin
                        st_we = 1'b1;
                        st_wd = stat;
                        d.st_wr = q.st_wr + 5'h01;
                    end
                    d.tst = T_IDLE;
                end
            end
            default: begin
                d.tst = T_IDLE;
            end
        endcase
        if (pkt_inc != pkt_dec) begin
            d.pkt_ready = pkt_inc ? q.pkt_ready + 12'h001 : q.pkt_ready - 12'h001;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.hst <= H_CMDA;
            q.tst <= T_IDLE;
            q.cfg <= `CFG_RESET;
        end else begin
            q <= d;
        end
    end

    // storage writes, no reset needed
    always_ff @(posedge pclk) begin
        if (data_we) begin
            data_mem[q.wr_ptr[`DATA_AW-1:0]] <= data_wd;
        end
        if (info_we) begin
            info_mem[q.info_wr[`INFO_AW-1:0]] <= info_wd;
        end
        if (st_we) begin
            stat_mem[q.st_wr[`STAT_AW-1:0]] <= st_wd;
        end
    end

    // outputs straight from the state register
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign mac_tx = q.mac;
    assign transmit_error_flag = q.err;

endmodule

// ---- rtl/tx_buffer_defines.svh ----
`ifndef TX_BUFFER_DEFINES_SVH
`define TX_BUFFER_DEFINES_SVH

// apb register byte addresses
`define ADDR_TX_DATA 8'h00
`define ADDR_TX_STATUS 8'h04
`define ADDR_TX_CONFIG 8'h08
`define ADDR_TX_INFO 8'h0C

// config register bits
`define CFG_DISCARD_OVERRUN_BIT 0
`define CFG_STORE_FORWARD_BIT 1
`define CFG_DEFER_CHECK_BIT 2
`define CFG_RESET 3'h0

// info register fields
`define INFO_USED_MSB 4
`define INFO_ERROR_BIT 16

// first command word layout
`define CMDA_SIZE_MSB 10
`define CMDA_LAST_BIT 12
`define CMDA_FIRST_BIT 13
`define CMDA_OFF_LSB 16
`define CMDA_OFF_MSB 21
`define CMDA_ALIGN_LSB 24
`define CMDA_ALIGN_MSB 25

// second command word layout
`define CMDB_TAG_LSB 16
`define CMDB_CRC_DIS_BIT 13
`define CMDB_PAD_DIS_BIT 12
`define CMDB_LEN_MSB 10

// end alignment codes and masks
`define ALIGN_16 2'h1
`define ALIGN_32 2'h2
`define ALIGN_MASK_4 12'h003
`define ALIGN_MASK_16 12'h00F
`define ALIGN_MASK_32 12'h01F

// storage depths (address widths)
`define DATA_AW 11
`define STAT_AW 4
`define INFO_AW 2

`endif

// ---- rtl/tx_buffer_pkg.sv ----
package tx_buffer_pkg;

    typedef enum logic [1:0] {
        H_CMDA = 2'b00,
        H_CMDB = 2'b01,
        H_DATA = 2'b10,
        H_UNPACK = 2'b11
    } host_state_e;

    typedef enum logic [1:0] {
        T_IDLE = 2'b00,
        T_SEND = 2'b01,
        T_WAIT = 2'b10
    } tx_state_e;

    // per-frame outcome reported by the mac transmitter
    typedef struct packed {
        logic loss_carrier;
        logic no_carrier;
        logic late_collision;
        logic excess_collisions;
        logic [3:0] collision_count;
        logic excess_deferral;
        logic underrun;
        logic deferred;
    } mac_result_s;

    // byte stream toward the mac transmitter
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
        logic crc_en;
        logic pad_en;
    } mac_tx_s;

    typedef struct packed {
        host_state_e hst;
        tx_state_e tst;
        logic [31:0] cmda;
        logic [31:0] pkt_b;
        logic [9:0] words;
        logic [9:0] widx;
        logic [31:0] word;
        logic [1:0] lane;
        logic [11:0] cum;
        logic [11:0] wr_ptr;
        logic [11:0] rd_ptr;
        logic [2:0] info_wr;
        logic [2:0] info_rd;
        logic [4:0] st_wr;
        logic [4:0] st_rd;
        logic st_over;
        logic [11:0] pkt_ready;
        logic [2:0] cfg;
        logic err;
        logic [17:0] cur_info;
        mac_tx_s mac;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_s;

endpackage

// ---- verification/tx_buffer_cmd_status_asserts.sv ----
`timescale 1ns/1ps
`include "tx_buffer_defines.svh"
module tx_buffer_cmd_status_asserts (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // mac side
    input wire tx_buffer_pkg::mac_tx_s mac_tx,
    input wire logic mac_ready,
    input wire logic mac_done,
    input wire tx_buffer_pkg::mac_result_s mac_result,
    input wire logic transmit_error_flag
);
    import tx_buffer_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // apb answer shape
    property p_pulse; pready |=> !pready; endproperty
    property p_slverr; pslverr |-> pready; endproperty
    property p_cause; pready |-> $past(psel) && $past(penable); endproperty
    // byte stream holds until taken, frame flags stay consistent
    property p_hold;
        mac_tx.valid && !mac_ready |=> mac_tx.valid && $stable(mac_tx.data) && $stable(mac_tx.last);
    endproperty
    property p_pad_crc; mac_tx.valid && !mac_tx.pad_en |-> mac_tx.crc_en; endproperty
    property p_flags;
        mac_tx.valid && !mac_tx.last |=> $stable(mac_tx.crc_en) && $stable(mac_tx.pad_en);
    endproperty
    // error flag behaviour
    property p_underrun; mac_done && mac_result.underrun |=> transmit_error_flag; endproperty
    property p_sticky;
        transmit_error_flag && !(psel && paddr == `ADDR_TX_INFO) |=> transmit_error_flag;
    endproperty
    // status word shape on read
    property p_status;
        pready && !pwrite && paddr == `ADDR_TX_STATUS |-> prdata[14:12] == 3'h0 && !prdata[7]
            && prdata[15] == (|{prdata[11:8], prdata[2:1]});
    endproperty
    a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
    a_slverr: assert property (p_slverr) else $error("pslverr without pready");
    a_cause: assert property (p_cause) else $error("pready without access phase");
    a_hold: assert property (p_hold) else $error("byte changed before taken");
    a_pad_crc: assert property (p_pad_crc) else $error("pad off without crc");
    a_flags: assert property (p_flags) else $error("frame flags moved");
    a_underrun: assert property (p_underrun) else $error("underrun no error");
    a_sticky: assert property (p_sticky) else $error("error flag dropped");
    a_status: assert property (p_status) else $error("status word shape");
    c_last: cover property (mac_tx.valid && mac_ready && mac_tx.last);
    c_slverr: cover property (pslverr);
    c_err: cover property ($rose(transmit_error_flag));
endmodule
bind tx_buffer_cmd_status tx_buffer_cmd_status_asserts tx_buffer_cmd_status_asserts_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mac_tx(mac_tx), .mac_ready(mac_ready), .mac_done(mac_done), .mac_result(mac_result),
    .transmit_error_flag(transmit_error_flag));

// ---- verification/mac_model.sv ----
`timescale 1ns/1ps
module mac_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // byte stream
    input wire tx_buffer_pkg::mac_tx_s mac_tx,
    output logic mac_ready,
    // frame outcome
    output logic mac_done,
    output tx_buffer_pkg::mac_result_s mac_result,
    // test controls
    input wire logic slow,
    input wire tx_buffer_pkg::mac_result_s res_in
);
    import tx_buffer_pkg::*;
    logic [7:0] got [0:1023];
    int n_got;
    int n_frames;
    int wait_q;
    logic crc_seen;
    logic pad_seen;
    // take bytes, stall every other cycle when slow, report three cycles after last
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mac_ready <= 1'b0;
            mac_done <= 1'b0;
            mac_result <= '0;
            n_got <= 0;
            n_frames <= 0;
            wait_q <= 0;
        end else begin
            mac_ready <= slow ? ~mac_ready : 1'b1;
            mac_done <= 1'b0;
            mac_result <= ~res_in; // junk outside the done pulse
            if (mac_tx.valid && mac_ready) begin
                got[n_got] <= mac_tx.data;
                n_got <= n_got + 1;
                crc_seen <= mac_tx.crc_en;
                pad_seen <= mac_tx.pad_en;
                if (mac_tx.last) wait_q <= 3;
            end
            if (wait_q > 0) wait_q <= wait_q - 1;
            if (wait_q == 1) begin
                mac_done <= 1'b1;
                mac_result <= res_in;
                n_frames <= n_frames + 1;
            end
        end
    end
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`include "tx_buffer_defines.svh"
module tb;
    import tx_buffer_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    mac_tx_s mac_tx;
    logic mac_ready;
    logic mac_done;
    mac_result_s mac_result;
    logic transmit_error_flag;
    logic slow = 1'b0;
    mac_result_s res_in = '0;
    logic [31:0] rd;
    logic rerr;
    logic [7:0] expq [$];
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    int nf = 0;
    int got0 = 0;
    always #50 pclk = ~pclk;
    tx_buffer_cmd_status tx_buffer_cmd_status_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mac_tx(mac_tx), .mac_ready(mac_ready),
        .mac_done(mac_done), .mac_result(mac_result), .transmit_error_flag(transmit_error_flag));
    mac_model mac_model_i (.pclk(pclk), .presetn(presetn), .mac_tx(mac_tx),
        .mac_ready(mac_ready), .mac_done(mac_done), .mac_result(mac_result), .slow(slow),
        .res_in(res_in));
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // watchdog
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fails++;
            conclude();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 300);
        if (n == 300) fails++;
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [31:0] exp_status(input logic [15:0] tag, input mac_result_s r,
            input logic dc);
        logic ed;
        ed = r.excess_deferral & dc;
        return {tag, r.loss_carrier | r.no_carrier | r.late_collision | r.excess_collisions
            | ed | r.underrun, 3'h0, r.loss_carrier, r.no_carrier, r.late_collision,
            r.excess_collisions, 1'b0, r.collision_count, ed, r.underrun, r.deferred};
    endfunction
    // write one buffer: command a, command b, then whole padded words
    task automatic send_buf(input logic [5:0] off, input logic [10:0] size, input logic [1:0] al,
            input logic fs, input logic ls, input logic [31:0] cmdb, input logic [7:0] base);
        int g;
        int words;
        logic [31:0] w;
        g = (al == `ALIGN_16) ? 16 : (al == `ALIGN_32) ? 32 : 4;
        words = ((int'(off) + int'(size) + g - 1) / g) * g / 4;
        apb(1'b1, `ADDR_TX_DATA, {6'h0, al, 2'h0, off, 2'h0, fs, ls, 1'b0, size});
        apb(1'b1, `ADDR_TX_DATA, cmdb);
        for (int i = 0; i < words; i++) begin
            for (int j = 0; j < 4; j++) w[8*j +: 8] = base + 8'(4 * i + j);
            apb(1'b1, `ADDR_TX_DATA, w);
        end
        for (int p = 0; p < int'(size); p++) expq.push_back(base + 8'(int'(off) + p));
        if (ls) nf++;
    endtask
    task automatic wait_frames();
        int t = 0;
        while (mac_model_i.n_frames < nf && t < 3000) begin
            @(posedge pclk);
            t++;
        end
        repeat (2) @(posedge pclk);
        check("frames", 32'(nf), 32'(mac_model_i.n_frames));
    endtask
    // judge bytes, frame flags and status word
    task automatic check_frame(input logic [15:0] tag, input logic dc, input logic crc,
            input logic pad);
        wait_frames();
        check("count", 32'(expq.size()), 32'(mac_model_i.n_got - got0));
        foreach (expq[k]) check("byte", 32'(expq[k]), 32'(mac_model_i.got[got0 + k]));
        got0 = mac_model_i.n_got;
        expq.delete();
        check("crc_en", 32'(crc), 32'(mac_model_i.crc_seen));
        check("pad_en", 32'(pad), 32'(mac_model_i.pad_seen));
        apb(1'b0, `ADDR_TX_STATUS, 32'h0);
        check("status", exp_status(tag, res_in, dc), rd);
    endtask
    task automatic t_regs();
        apb(1'b0, `ADDR_TX_CONFIG, 32'h0);
        check("cfg reset", 32'h0, rd);
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped err", 32'h1, 32'(rerr));
        check("unmapped data", 32'h0, rd);
        $display("test regs done");
    endtask
    task automatic t_single();
        apb(1'b1, `ADDR_TX_CONFIG, 32'h4);
        res_in <= '{collision_count: 4'h3, excess_deferral: 1'b1, deferred: 1'b1, default: 1'b0};
        send_buf(6'h06, 11'd5, `ALIGN_16, 1'b1, 1'b1, 32'hBEEF_2005, 8'hA0);
        check_frame(16'hBEEF, 1'b1, 1'b0, 1'b1);
        check("no error", 32'h0, 32'(transmit_error_flag));
        $display("test single done");
    endtask
    task automatic t_pad();
        apb(1'b1, `ADDR_TX_CONFIG, 32'h0);
        res_in <= '{underrun: 1'b1, late_collision: 1'b1, excess_deferral: 1'b1, default: 1'b0};
        send_buf(6'h1F, 11'd2, `ALIGN_32, 1'b1, 1'b1, 32'h1234_3002, 8'h40);
        check_frame(16'h1234, 1'b0, 1'b1, 1'b0);
        apb(1'b0, `ADDR_TX_INFO, 32'h0);
        check("underrun error", 32'h1, 32'(rd[16]));
        apb(1'b1, `ADDR_TX_INFO, 32'h0001_0000);
        apb(1'b0, `ADDR_TX_INFO, 32'h0);
        check("error cleared", 32'h0, 32'(rd[16]));
        $display("test pad done");
    endtask
    task automatic t_multi();
        slow <= 1'b1;
        apb(1'b1, `ADDR_TX_CONFIG, 32'h2);
        res_in <= '{loss_carrier: 1'b1, no_carrier: 1'b1, excess_collisions: 1'b1, default: 1'b0};
        send_buf(6'h03, 11'd3, 2'h0, 1'b1, 1'b0, 32'h0077_0009, 8'h10);
        send_buf(6'h00, 11'd4, `ALIGN_16, 1'b0, 1'b0, 32'h0077_0009, 8'h60);
        check("sf hold", got0, mac_model_i.n_got);
        send_buf(6'h01, 11'd2, 2'h0, 1'b0, 1'b1, 32'h0077_0009, 8'hC0);
        check_frame(16'h0077, 1'b0, 1'b1, 1'b1);
        check("no error", 32'h0, 32'(transmit_error_flag));
        slow <= 1'b0;
        $display("test multi done");
    endtask
    task automatic t_errors();
        res_in <= '0;
        for (int k = 0; k < 2; k++) begin
            send_buf(6'h00, 11'd2, 2'h0, 1'b1, 1'b0, k ? 32'h0001_0004 : 32'h0005, 8'h20);
            send_buf(6'h00, 11'd2, 2'h0, 1'b0, 1'b1, k ? 32'h0002_0004 : 32'h0005, 8'h30);
            wait_frames();
            expq.delete();
            got0 = mac_model_i.n_got;
            apb(1'b0, `ADDR_TX_STATUS, 32'h0);
            apb(1'b0, `ADDR_TX_INFO, 32'h0);
            check("error set", 32'h1, 32'(rd[16]));
            apb(1'b1, `ADDR_TX_INFO, 32'h0001_0000);
        end
        $display("test errors done");
    endtask
    task automatic t_full();
        for (int i = 0; i < 17; i++)
            send_buf(6'h00, 11'd1, 2'h0, 1'b1, 1'b1, {16'(16'h0100 + i), 16'h0001}, 8'h50);
        nf--;
        wait_frames();
        repeat (100) @(posedge pclk);
        check("stalled", 32'(nf), 32'(mac_model_i.n_frames));
        apb(1'b0, `ADDR_TX_INFO, 32'h0);
        check("used", 32'd16, 32'(rd[4:0]));
        apb(1'b0, `ADDR_TX_STATUS, 32'h0);
        check("first tag", 32'h0100, 32'(rd[31:16]));
        nf++;
        wait_frames();
        apb(1'b1, `ADDR_TX_CONFIG, 32'h1);
        send_buf(6'h00, 11'd1, 2'h0, 1'b1, 1'b1, 32'h0200_0001, 8'h50);
        wait_frames();
        apb(1'b0, `ADDR_TX_INFO, 32'h0);
        check("used overrun", 32'h0, 32'(rd[4:0]));
        check("no overrun error", 32'h0, 32'(rd[16]));
        $display("test full done");
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_single();
        t_pad();
        t_multi();
        t_errors();
        t_full();
        conclude();
    end
endmodule
